// ---- hdl/jtag_tap_port_pins.sv ----
// Test access port controller, shift paths and debug word hand-off.
//
// Operation
// - Test clock alone times all test logic.
// - Mode select sampled on rising test clock.
// - Data input shifted in on rising edge.
// - Data output driven only in shift states.
// - Data output changes on falling edges only.
// - Low test reset resets controller at once.
// - Main reset leaves port and held debug word intact, clears dbgWord.
// - Pull-disable bit drops the three pull-ups.
module jtag_tap_port_pins
	import jtag_tap_pkg::*;
#(
	parameter logic [DR_WIDTH-1:0] IDCODE = IDCODE_VAL
)
(
	input wire logic ref_clk, // System clock, 125 MHz
	input wire logic rst, // System reset, synchronous, active high
	input wire logic tck, // Test clock from the host
	input wire logic tms, // Test mode select
	input wire logic tdi, // Test data input
	input wire logic trstN, // Test reset, active low, asynchronous
	input wire logic pullDisable, // Test-port pull-disable control bit
	output tdo_pin_t tdoPin, // Test data output value and enable
	output pull_en_t pullEn, // Pull-up enables of the test inputs
	output logic [DBG_WIDTH-1:0] dbgWord, // Last debug word, system side
	output logic dbgStrobe // One-cycle pulse on a new debug word
);

	// ********************************************************************
	// Elaboration checks
	// ********************************************************************
	if (DBG_WIDTH > DR_WIDTH) begin : gCheck
		$error("Debug word does not fit the data shift path.");
	end

	// ********************************************************************
	// Controller, test clock domain
	// ********************************************************************
	tap_state_t state_q;
	tap_state_t state_d;

	tap_next_state uNext (
		.cur(state_q),
		.modeSel(tms),
		.nxt(state_d)
	);

	// The test reset acts without the clock; the main reset is not
	// connected here, so a system reset alone keeps the port state.
	// test clock times all
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			state_q <= TEST_LOGIC_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ********************************************************************
	// Instruction path
	// ********************************************************************
	logic [IR_WIDTH-1:0] irShift_q;
	logic [IR_WIDTH-1:0] irHold_q;

	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			irShift_q <= IR_CAPTURE_VAL;
		end else if (state_q == CAPTURE_IR) begin
			irShift_q <= IR_CAPTURE_VAL;
		end else if (state_q == SHIFT_IR) begin
			irShift_q <= {tdi, irShift_q[IR_WIDTH-1:1]};
		end
	end

	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			irHold_q <= INSTR_IDCODE;
		end else if (state_q == TEST_LOGIC_RESET) begin
			irHold_q <= INSTR_IDCODE;
		end else if (state_q == UPDATE_IR) begin
			irHold_q <= irShift_q;
		end
	end

	// ********************************************************************
	// Data path
	// ********************************************************************
	logic [DR_WIDTH-1:0] drShift_q;
	logic [DBG_WIDTH-1:0] dbgHold_q;
	logic dbgToggle_q;
	logic selIdcode;
	logic selDebug;

	assign selIdcode = (irHold_q == INSTR_IDCODE);
	assign selDebug = (irHold_q == INSTR_DEBUG);

	// Each selected path has its own length; data enters at its top bit
	// and leaves at bit zero, so the output bit is always drShift_q[0].
	// shift data bits
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			drShift_q <= '0;
		end else if (state_q == CAPTURE_DR) begin
			if (selIdcode) begin
				drShift_q <= IDCODE;
			end else if (selDebug) begin
				drShift_q <= {{(DR_WIDTH-DBG_WIDTH){1'b0}}, dbgHold_q};
			end else begin
				drShift_q <= '0;
			end
		end else if (state_q == SHIFT_DR) begin
			if (selIdcode) begin
				drShift_q <= {tdi, drShift_q[DR_WIDTH-1:1]};
			end else if (selDebug) begin
				drShift_q <= {{(DR_WIDTH-DBG_WIDTH){1'b0}}, tdi,
					drShift_q[DBG_WIDTH-1:1]};
			end else begin
				drShift_q <= {{(DR_WIDTH-1){1'b0}}, tdi};
			end
		end
	end

	// The held word only changes on Update-DR, so it is stable for many
	// system cycles while the toggle crosses; that makes it safe to copy.
	// debug state survives main reset
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			dbgHold_q <= DBG_RESET_VAL;
			dbgToggle_q <= 1'b0;
		end else if (state_q == UPDATE_DR && selDebug) begin
			dbgHold_q <= drShift_q[DBG_WIDTH-1:0];
			dbgToggle_q <= ~dbgToggle_q;
		end
	end

	// ********************************************************************
	// Data output, falling test clock edge
	// ********************************************************************
	tdo_pin_t tdo_q;

	always_ff @(negedge tck or negedge trstN) begin
		if (!trstN) begin
			tdo_q <= '0;
		end else begin
			tdo_q.oe <= (state_q == SHIFT_IR) || (state_q == SHIFT_DR);
			tdo_q.out <= (state_q == SHIFT_IR) ? irShift_q[0]
				: drShift_q[0];
		end
	end

	assign tdoPin = tdo_q;

	// ********************************************************************
	// Debug word crossing into the system clock domain
	// ********************************************************************
	logic togSync1_q;
	logic togSync2_q;
	logic togSeen_q;
	logic [DBG_WIDTH-1:0] dbgWord_q;
	logic dbgStrobe_q;

	always_ff @(posedge ref_clk) begin
		togSync1_q <= dbgToggle_q;
		togSync2_q <= togSync1_q;
	end

	// On a system reset the seen copy is realigned with the toggle, so
	// the reset itself never fakes a new word.
	// no spurious word
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			togSeen_q <= togSync2_q;
			dbgStrobe_q <= 1'b0;
		end else begin
			togSeen_q <= togSync2_q;
			dbgStrobe_q <= togSync2_q ^ togSeen_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dbgWord_q <= DBG_RESET_VAL;
		end else if (togSync2_q ^ togSeen_q) begin
			dbgWord_q <= dbgHold_q;
		end
	end

	assign dbgWord = dbgWord_q;
	assign dbgStrobe = dbgStrobe_q;

	// ********************************************************************
	// Pull-up control
	// ********************************************************************
	pull_en_t pullEn_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pullEn_q <= '1;
		end else begin
			pullEn_q.tms <= ~pullDisable;
			pullEn_q.tdi <= ~pullDisable;
			pullEn_q.trst <= ~pullDisable;
		end
	end

	assign pullEn = pullEn_q;

endmodule : jtag_tap_port_pins

// ---- hdl/jtag_tap_pkg.sv ----
// Shared types and constants for the test access port block.
package jtag_tap_pkg;

	// ********************************************************************
	// Widths and reset values
	// ********************************************************************
	localparam int IR_WIDTH = 4;
	localparam int DR_WIDTH = 32;
	localparam int DBG_WIDTH = 16;
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VAL = 4'h1;
	localparam logic [DBG_WIDTH-1:0] DBG_RESET_VAL = 16'h0000;
	// Identification value is arbitrary and names no part.
	localparam logic [DR_WIDTH-1:0] IDCODE_VAL = 32'h1234_5671;

	// ********************************************************************
	// Instruction codes
	// ********************************************************************
	localparam logic [IR_WIDTH-1:0] INSTR_IDCODE = 4'h2;
	localparam logic [IR_WIDTH-1:0] INSTR_DEBUG = 4'h7;
	localparam logic [IR_WIDTH-1:0] INSTR_BYPASS = 4'hF;

	// ********************************************************************
	// Controller states, Gray coded in the order listed
	// ********************************************************************
	typedef enum logic [3:0] {
		TEST_LOGIC_RESET = 4'h0,
		RUN_TEST_IDLE = 4'h1,
		SELECT_DR = 4'h3,
		CAPTURE_DR = 4'h2,
		SHIFT_DR = 4'h6,
		EXIT1_DR = 4'h7,
		PAUSE_DR = 4'h5,
		EXIT2_DR = 4'h4,
		UPDATE_DR = 4'hC,
		SELECT_IR = 4'hD,
		CAPTURE_IR = 4'hF,
		SHIFT_IR = 4'hE,
		EXIT1_IR = 4'hA,
		PAUSE_IR = 4'hB,
		EXIT2_IR = 4'h9,
		UPDATE_IR = 4'h8
	} tap_state_t;

	// ********************************************************************
	// Carriers
	// ********************************************************************
	typedef struct packed {
		logic tms;
		logic tdi;
		logic trst;
	} pull_en_t;

	typedef struct packed {
		logic out;
		logic oe;
	} tdo_pin_t;

endpackage : jtag_tap_pkg

// ---- hdl/tap_next_state.sv ----
// Next-state logic of the sixteen-state test access port controller.
module tap_next_state
	import jtag_tap_pkg::*;
(
	input tap_state_t cur, // Present controller state
	input wire logic modeSel, // Sampled mode select bit
	output tap_state_t nxt // State after the coming rising edge
);

	always_comb begin
		nxt = cur;
		case (cur)
			TEST_LOGIC_RESET: nxt = modeSel ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
			RUN_TEST_IDLE: nxt = modeSel ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_DR: nxt = modeSel ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR: nxt = modeSel ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: nxt = modeSel ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: nxt = modeSel ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR: nxt = modeSel ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: nxt = modeSel ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR: nxt = modeSel ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_IR: nxt = modeSel ? TEST_LOGIC_RESET : CAPTURE_IR;
			CAPTURE_IR: nxt = modeSel ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: nxt = modeSel ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: nxt = modeSel ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR: nxt = modeSel ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: nxt = modeSel ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR: nxt = modeSel ? SELECT_DR : RUN_TEST_IDLE;
			default: nxt = TEST_LOGIC_RESET;
		endcase
	end

endmodule : tap_next_state

// ---- verif/jtag_tap_port_pins_assertions.sv ----
// Concurrent checks on the pins of the test access port block.
module jtag_tap_port_pins_assertions
	import jtag_tap_pkg::*;
(
	input wire logic ref_clk, // System clock
	input wire logic rst, // System reset
	input wire logic tck, // Test clock
	input wire logic tms, // Mode select
	input wire logic tdi, // Data in
	input wire logic trstN, // Test reset
	input wire logic pullDisable, // Pull-disable bit
	input tdo_pin_t tdoPin, // Data out pin
	input pull_en_t pullEn, // Pull enables
	input logic [DBG_WIDTH-1:0] dbgWord, // Debug word
	input logic dbgStrobe // Word strobe
);
	// ****
	// Checks
	// ****
	pull_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> pullEn == {3{~$past(pullDisable)}}) else $error("pull follow");
	pull_reset_a: assert property (@(posedge ref_clk)
		rst |=> pullEn == 3'h7) else $error("pull reset");
	strobe_once_a: assert property (@(posedge ref_clk) disable iff (rst)
		dbgStrobe |=> !dbgStrobe) else $error("strobe width");
	word_strobe_a: assert property (@(posedge ref_clk) disable iff (rst)
		!$past(rst) && $changed(dbgWord) |-> dbgStrobe) else $error("word");
	// Sampling on the system clock shows which tck phase launched a change.
	tdo_fall_a: assert property (@(posedge ref_clk) disable iff (!trstN)
		$changed(tdoPin) |-> !tck) else $error("tdo edge");
	oe_reset_a: assert property (@(posedge ref_clk)
		!trstN |-> !tdoPin.oe) else $error("oe in reset");
	oe_exit_a: assert property (@(posedge tck) disable iff (!trstN)
		tms |=> !tdoPin.oe) else $error("oe exit");
	oe_enter_a: assert property (@(posedge tck) disable iff (!trstN)
		$rose(tdoPin.oe) |-> !$past(tms)) else $error("oe enter");
	cover property (@(posedge ref_clk) dbgStrobe);
	cover property (@(posedge tck) $rose(tdoPin.oe));
	cover property (@(posedge ref_clk) pullDisable ##1 pullEn == 3'h0);
endmodule : jtag_tap_port_pins_assertions

bind jtag_tap_port_pins jtag_tap_port_pins_assertions
	jtag_tap_port_pins_assertions_inst (.ref_clk, .rst, .tck, .tms, .tdi,
	.trstN, .pullDisable, .tdoPin, .pullEn, .dbgWord, .dbgStrobe);

// ---- verif/jtag_host_model.sv ----
// Behavioural model of the external test host.
module jtag_host_model (
	output logic tck, // Test clock, idle low
	output logic tms, // Mode select
	output logic tdi, // Data in
	input wire logic tdoWire // Resolved data out line
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// Host cycles
	// ****
	// The clock stands low between calls, as a gated probe clock does.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// Drive low phase.
	// Edges sit off the system clock grid, so the clocks share no phase.
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#21.3 tck = 1'b1;
		o = tdoWire;
		#24 tck = 1'b0;
		#2.7;
	endtask : step
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = 32'h0;
		step(1'b1, 1'b1, o);
		if (ir) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask : scan
endmodule : jtag_host_model

// ---- verif/testbench.sv ----
// Self-checking bench of the test access port block.
module testbench;
	import jtag_tap_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [3:0] ir;
		logic [5:0] len;
		logic [31:0] din;
		logic [31:0] exp;
	} row_t;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic trstN = 1'b1;
	logic pullDisable = 1'b0;
	logic tck, tms, tdi, tdoWire, b;
	tdo_pin_t tdoPin;
	pull_en_t pullEn;
	logic [DBG_WIDTH-1:0] dbgWord;
	logic dbgStrobe;
	logic [31:0] got;
	int error_cnt = 0;
	int tests_run = 0;
	int strobeCnt = 0;
	row_t rows [5] = '{'{INSTR_IDCODE, 6'h20, 32'h0, IDCODE_VAL},
		'{INSTR_DEBUG, 6'h10, 32'hA5C3, 32'h0},
		'{INSTR_DEBUG, 6'h10, 32'h5A3C, 32'hA5C3},
		'{INSTR_BYPASS, 6'h8, 32'hC5, 32'h8A},
		'{4'h3, 6'h8, 32'h3A, 32'h74}};
	// ****
	// Harness
	// ****
	always #4 ref_clk = ~ref_clk;
	// The data out line carries a pull-up while nobody drives it.
	assign tdoWire = tdoPin.oe ? tdoPin.out : 1'b1;
	always @(posedge ref_clk) if (dbgStrobe === 1'b1) strobeCnt++;
	jtag_tap_port_pins jtag_tap_port_pins_inst (.ref_clk, .rst, .tck, .tms,
		.tdi, .trstN, .pullDisable, .tdoPin, .pullEn, .dbgWord, .dbgStrobe);
	jtag_host_model jtag_host_model_inst (.tck, .tms, .tdi, .tdoWire);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic results;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	initial begin
		#200us;
		error_cnt++;
		results();
	end
	// ****
	// Tests
	// ****
	initial begin
		// The test reset needs a real falling edge to reach the port.
		@(negedge ref_clk);
		trstN = 1'b0;
		repeat (7) @(negedge ref_clk);
		rst = 1'b0;
		trstN = 1'b1;
		@(negedge ref_clk);
		jtag_host_model_inst.step(1'b0, 1'b1, b);
		jtag_host_model_inst.scan(1'b0, 32, 32'h0, got);
		chk(got, IDCODE_VAL);
		foreach (rows[i]) begin
			jtag_host_model_inst.scan(1'b1, 4, {28'h0, rows[i].ir}, got);
			chk(got, {28'h0, IR_CAPTURE_VAL});
			jtag_host_model_inst.scan(1'b0, rows[i].len, rows[i].din, got);
			chk(got, rows[i].exp);
		end
		repeat (6) @(negedge ref_clk);
		chk(strobeCnt, 2);
		chk({16'h0, dbgWord}, 32'h5A3C);
		jtag_host_model_inst.scan(1'b1, 4, {28'h0, INSTR_DEBUG}, got);
		rst = 1'b1;
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		chk({16'h0, dbgWord}, 32'h0);
		jtag_host_model_inst.scan(1'b0, 16, 32'h0, got);
		chk(got, 32'h5A3C);
		pullDisable = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(pullEn, 32'h0);
		pullDisable = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(pullEn, 32'h7);
		jtag_host_model_inst.step(1'b1, 1'b1, b);
		jtag_host_model_inst.step(1'b0, 1'b1, b);
		jtag_host_model_inst.step(1'b0, 1'b1, b);
		chk(tdoPin.oe, 32'h1);
		trstN = 1'b0;
		@(negedge ref_clk);
		chk(tdoPin.oe, 32'h0);
		trstN = 1'b1;
		jtag_host_model_inst.step(1'b0, 1'b1, b);
		jtag_host_model_inst.scan(1'b0, 32, 32'h0, got);
		chk(got, IDCODE_VAL);
		jtag_host_model_inst.scan(1'b1, 4, {28'h0, INSTR_BYPASS}, got);
		repeat (5) jtag_host_model_inst.step(1'b1, 1'b1, b);
		jtag_host_model_inst.step(1'b0, 1'b1, b);
		jtag_host_model_inst.scan(1'b0, 32, 32'h0, got);
		chk(got, IDCODE_VAL);
		results();
	end
endmodule : testbench
